// [src/llc_defines.svh]
`ifndef LLC_DEFINES_SVH
`define LLC_DEFINES_SVH

// Register byte offsets on the APB window
`define LLC_STATUS_OFF 8'h00
`define LLC_CFG_BASE 8'h10
`define LLC_TAB_BASE 8'h20
// Stride between per-cell registers
`define LLC_STRIDE 8'h04

// Field widths
`define LLC_CFG_W 13
`define LLC_TAB_W 16
`define LLC_SHIFT_MAX 8

// STATUS field positions
`define LLC_ST_STORE_LSB 0
`define LLC_ST_TABLE_LSB 4
`define LLC_ST_CARRY_BIT 8

// Reset values
`define LLC_CFG_RST 13'h0000
`define LLC_TAB_RST 16'h0000

`endif

// [src/llc_pkg.sv]
package llc_pkg;

   // Operating mode of one table
   typedef enum logic [1:0] {
      LLC_MODE_COMB = 2'b00,
      LLC_MODE_MEM = 2'b01,
      LLC_MODE_SHIFT = 2'b10,
      LLC_MODE_RSVD = 2'b11
   } llc_mode_t;

   // Source of the cell storage element
   typedef enum logic [1:0] {
      LLC_STORE_WIDE = 2'b00,
      LLC_STORE_C = 2'b01,
      LLC_STORE_D = 2'b10,
      LLC_STORE_E = 2'b11
   } llc_store_t;

   // Five routed inputs of one cell
   typedef struct packed {
      logic e;
      logic d;
      logic c;
      logic b;
      logic a;
   } llc_in_t;

   // Per-cell configuration word, bit 12 down to bit 0
   typedef struct packed {
      logic booth_en;
      logic fifth_mux;
      llc_store_t store_sel;
      logic cd_to_table;
      logic cascade;
      logic [2:0] shift_len;
      logic sync_read;
      logic dual_port;
      llc_mode_t mode;
   } llc_cfg_t;

endpackage

// [src/llc_carry.sv]
`timescale 1ns/10ps

// One single-bit full adder of the carry chain
module llc_carry (
   input wire logic x,
   input wire logic y,
   input wire logic cin,
   output logic sum,
   output logic cout
);
   // Plain ripple form; chain delay grows with cell count
   assign sum = x ^ y ^ cin;
   assign cout = (x & y) | (cin & (x ^ y));
endmodule

// [src/llc_table.sv]
`timescale 1ns/10ps
`include "llc_defines.svh"

// Four-input table usable as logic, memory or shift register
module llc_table #(
   parameter int DEPTH = `LLC_TAB_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire llc_pkg::llc_mode_t mode,
   input wire logic sync_read,
   input wire logic [2:0] shift_len,
   input wire logic cfg_we,
   input wire logic [DEPTH-1:0] cfg_data,
   input wire logic [3:0] addr_a,
   input wire logic [3:0] addr_b,
   input wire logic mem_we,
   input wire logic wr_data,
   input wire logic shift_en,
   input wire logic shift_in,
   input wire logic clk_en,
   output logic look,
   output logic look_b,
   output logic [DEPTH-1:0] contents
);
   logic [DEPTH-1:0] mem;
   logic [DEPTH-1:0] next_mem;
   logic rd_q;
   wire logic is_shift = (mode == llc_pkg::LLC_MODE_SHIFT);
   wire logic async_rd = mem[addr_a];
   wire logic tap = mem[shift_len];

   // Per-bit next value; a software load wins over fabric writes
   genvar k;
   generate
      for (k = 0; k < DEPTH; k++) begin : g_bit
         wire logic wr_hit = mem_we && (addr_a == 4'(k));
         if (k == 0) begin : g_first
            assign next_mem[k] = cfg_we ? cfg_data[k] : wr_hit ? wr_data :
               shift_en ? shift_in : mem[k];
         end else if (k < `LLC_SHIFT_MAX) begin : g_chain
            assign next_mem[k] = cfg_we ? cfg_data[k] : wr_hit ? wr_data :
               shift_en ? mem[k-1] : mem[k];
         end else begin : g_plain
            assign next_mem[k] = cfg_we ? cfg_data[k] : wr_hit ? wr_data : mem[k];
         end
      end
   endgenerate

   // Storage and registered read port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem <= `LLC_TAB_RST;
         rd_q <= 1'b0;
      end else begin
         mem <= next_mem;
         if (clk_en) begin
            rd_q <= async_rd;
         end
      end
   end

   // Output selection by mode
   assign look = is_shift ? tap : (sync_read && mode == llc_pkg::LLC_MODE_MEM) ? rd_q : async_rd;
   assign look_b = mem[addr_b];
   assign contents = mem;
endmodule

// [src/llc_cell.sv]
`timescale 1ns/10ps
`include "llc_defines.svh"

// Operation
// - Table, one-bit full adder and AND gate
// - AND output may feed adder input
// - Five inputs, two always reach table
// - Third, fourth inputs: table or feed-through
// - Fifth input: write data, select, feed-through
// - Logic mode gives any four-input function
// - Memory mode, 64 bits per unit
// - Memory single or dual port
// - Memory read synchronous or asynchronous
// - Set/reset becomes write enable in memory
// - Primary cell clock times memory access
// - Shift length selectable 1 to 8
// - Four shift registers, cascadable
module llc_cell #(
   parameter int NCELL = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire llc_pkg::llc_in_t [NCELL-1:0] cell_in,
   input wire logic set_reset,
   input wire logic primary_cell_clock,
   input wire logic carry_in,
   output logic [NCELL-1:0] cell_storage_element,
   output logic [NCELL-1:0] table_q,
   output logic [NCELL-1:0] port_b_q,
   output logic [NCELL-1:0] sum_q,
   output logic carry_out
);

   // Configuration and table images, one per cell
   llc_pkg::llc_cfg_t cfg [NCELL];
   logic [`LLC_TAB_W-1:0] tab_img [NCELL];

   // Combinational results per cell
   logic [NCELL-1:0] tab_out;
   logic [NCELL-1:0] tab_b;
   logic [NCELL-1:0] wide;
   logic [NCELL-1:0] store_d;
   logic [NCELL-1:0] sum_w;
   logic [NCELL:0] chain;
   logic [NCELL-1:0] mem_mode;

   // APB decode terms
   logic [NCELL-1:0] hit_cfg;
   logic [NCELL-1:0] hit_tab;
   logic [31:0] rd_term [NCELL];
   logic [31:0] rd_word;

   // First access cycle; the answer comes one cycle later
   wire logic acc = psel & penable & ~pready;
   // Write commits on the edge that samples pready high
   wire logic wr_fire = psel & penable & pready & pwrite;
   wire logic hit_stat = (paddr == `LLC_STATUS_OFF);
   wire logic mapped = hit_stat | (|hit_cfg) | (|hit_tab);

   // Set/reset doubles as write enable once any table holds memory
   // Shared write enable
   wire logic sr_is_we = |mem_mode;

   // Status word shows live cell state
   wire logic [31:0] stat_word = {
      23'h000000, carry_out, tab_out, cell_storage_element
   };

   assign chain[0] = carry_in;

   genvar i;
   generate
      for (i = 0; i < NCELL; i++) begin : g_cell
         llc_pkg::llc_in_t in;
         llc_pkg::llc_in_t nxt;
         logic [3:0] addr_a;
         logic [3:0] addr_b;
         logic c_t;
         logic d_t;
         logic shift_in;
         logic and_out;
         logic y_op;
         logic cfg_wr;
         logic tab_wr;

         assign in = cell_in[i];
         // Neighbour inputs give the second read address
         assign nxt = cell_in[(i + 1) % NCELL];

         // Register decode for this cell
         assign hit_cfg[i] = (paddr == 8'(`LLC_CFG_BASE + i * `LLC_STRIDE));
         assign hit_tab[i] = (paddr == 8'(`LLC_TAB_BASE + i * `LLC_STRIDE));
         assign cfg_wr = wr_fire & hit_cfg[i];
         assign tab_wr = wr_fire & hit_tab[i];
         assign rd_term[i] = hit_cfg[i] ? {19'h00000, cfg[i]} :
            hit_tab[i] ? {16'h0000, tab_img[i]} : 32'h00000000;

         assign mem_mode[i] = (cfg[i].mode == llc_pkg::LLC_MODE_MEM);

         // a and b always reach the table
         // Outside memory mode, c and d reach the table only when routed there
         assign c_t = cfg[i].cd_to_table ? in.c : 1'b0;
         assign d_t = cfg[i].cd_to_table ? in.d : 1'b0;

         // Memory uses all four inputs as address
         assign addr_a = mem_mode[i] ? {in.d, in.c, in.b, in.a} :
            {d_t, c_t, in.b, in.a};
         // Dual port adds a read-only address
         assign addr_b = cfg[i].dual_port ? {nxt.d, nxt.c, nxt.b, nxt.a} : addr_a;

         // Cascade takes the previous tap as serial input
         assign shift_in = cfg[i].cascade ? tab_out[(i + NCELL - 1) % NCELL] : in.e;

         // Contents decide the function in logic mode
         llc_table #(
            .DEPTH(`LLC_TAB_W)
         ) u_table (
            .pclk(pclk),
            .presetn(presetn),
            .mode(cfg[i].mode),
            .sync_read(cfg[i].sync_read),
            .shift_len(cfg[i].shift_len),
            .cfg_we(tab_wr),
            .cfg_data(pwdata[`LLC_TAB_W-1:0]),
            .addr_a(addr_a),
            .addr_b(addr_b),
            // Write only on a clock pulse with enable
            // Primary clock times writes and reads
            .mem_we(mem_mode[i] & set_reset & primary_cell_clock),
            .wr_data(in.e),
            .shift_en((cfg[i].mode == llc_pkg::LLC_MODE_SHIFT) & primary_cell_clock),
            .shift_in(shift_in),
            .clk_en(primary_cell_clock),
            .look(tab_out[i]),
            .look_b(tab_b[i]),
            .contents(tab_img[i])
         );

         // Fifth input as mux select between neighbours
         assign wide[i] = (cfg[i].fifth_mux & in.e) ? tab_out[(i + 1) % NCELL] : tab_out[i];

         // Feed-through of c, d or e to storage
         assign store_d[i] = (cfg[i].store_sel == llc_pkg::LLC_STORE_C) ? in.c :
            (cfg[i].store_sel == llc_pkg::LLC_STORE_D) ? in.d :
            (cfg[i].store_sel == llc_pkg::LLC_STORE_E) ? in.e : wide[i];

         // AND gate replaces the second operand
         assign and_out = in.a & in.b;
         assign y_op = cfg[i].booth_en ? and_out : in.b;

         llc_carry u_carry (
            .x(tab_out[i]),
            .y(y_op),
            .cin(chain[i]),
            .sum(sum_w[i]),
            .cout(chain[i+1])
         );

         // Configuration register of this cell
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cfg[i] <= `LLC_CFG_RST;
            end else if (cfg_wr) begin
               cfg[i] <= pwdata[`LLC_CFG_W-1:0];
            end
         end

         // Storage element; set/reset clears it only outside memory use
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cell_storage_element[i] <= 1'b0;
            end else if (primary_cell_clock) begin
               // Reset role lost while acting as write enable
               if (set_reset & ~sr_is_we) begin
                  cell_storage_element[i] <= 1'b0;
               end else begin
                  cell_storage_element[i] <= store_d[i];
               end
            end
         end
      end
   endgenerate

   // Fold per-cell read terms into one word
   always_comb begin
      rd_word = hit_stat ? stat_word : 32'h00000000;
      for (int n = 0; n < NCELL; n++) begin
         rd_word = rd_word | rd_term[n];
      end
   end

   // APB answer: one wait state, data and error registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= acc;
         if (acc) begin
            // Unmapped address answers with error and zero data
            pslverr <= ~mapped;
            prdata <= (mapped && !pwrite) ? rd_word : 32'h00000000;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // Registered fabric outputs, sampled every pclk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         table_q <= '0;
         port_b_q <= '0;
         sum_q <= '0;
         carry_out <= 1'b0;
      end else begin
         table_q <= tab_out;
         port_b_q <= tab_b;
         sum_q <= sum_w;
         carry_out <= chain[NCELL];
      end
   end

endmodule

// [test/llc_chk.sv]
`timescale 1ns/10ps

// Bus answer timing and reset state of the cell array
module llc_chk #(
   parameter int NCELL = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [NCELL-1:0] cell_storage_element,
   input wire logic [NCELL-1:0] table_q
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Word slots of the map; the decode assumes four cells
   wire mapped = (paddr == 8'h00) ||
      ((paddr[7:4] == 4'h1 || paddr[7:4] == 4'h2) && paddr[1:0] == 2'h0);
   // Read completing this cycle
   wire rd_done = pready && !pwrite;
   sequence s_req;
      psel && penable && !pready;
   endsequence
   sequence s_ans;
      s_req ##1 pready;
   endsequence
   property p_ans;
      s_req |=> pready;
   endproperty
   a_ans: assert property (p_ans) else $error("no answer after access");
   property p_one;
      s_ans |=> !pready;
   endproperty
   a_one: assert property (p_one) else $error("answer longer than one cycle");
   property p_cause;
      pready |-> $past(psel && penable);
   endproperty
   a_cause: assert property (p_cause) else $error("answer without request");
   property p_err;
      pready |-> pslverr == !mapped;
   endproperty
   a_err: assert property (p_err) else $error("error flag wrong for address");
   property p_edat;
      pslverr |-> prdata == 32'h0;
   endproperty
   a_edat: assert property (p_edat) else $error("data on refused access");
   property p_cfg;
      rd_done && paddr[7:4] == 4'h1 |-> prdata[31:13] == 19'h0;
   endproperty
   a_cfg: assert property (p_cfg) else $error("config upper bits not zero");
   property p_tab;
      rd_done && paddr[7:4] == 4'h2 |-> prdata[31:16] == 16'h0;
   endproperty
   a_tab: assert property (p_tab) else $error("table upper bits not zero");
   property p_st;
      rd_done && paddr == 8'h00 |-> prdata[31:9] == 23'h0;
   endproperty
   a_st: assert property (p_st) else $error("status upper bits not zero");
   property p_rst;
      $rose(presetn) |-> !pready && table_q == '0 && cell_storage_element == '0;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not clear after reset");
endmodule

bind llc_cell llc_chk #(.NCELL(NCELL)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .cell_storage_element(cell_storage_element), .table_q(table_q));

// [test/llc_fabric.sv]
`timescale 1ns/10ps

// Neighbouring fabric; only cell 0 is driven, the rest idle low
module llc_fabric (
   input wire logic pclk,
   output llc_pkg::llc_in_t [3:0] cell_in,
   output logic set_reset,
   output logic primary_cell_clock,
   output logic carry_in
);
   initial begin
      cell_in = '0;
      set_reset = 1'b0;
      primary_cell_clock = 1'b0;
      carry_in = 1'b0;
   end
   // Carry into cell 0, launched just after an edge; held until changed
   task automatic set_carry(input logic c);
      carry_in <= c;
   endtask
   // Launch one cycle of values just after an edge
   task automatic step(input llc_pkg::llc_in_t i, input logic sr, input logic p);
      cell_in[0] <= i;
      set_reset <= sr;
      primary_cell_clock <= p;
      @(posedge pclk);
   endtask
endmodule

// [test/testbench.sv]
`timescale 1ns/10ps

// Self-checking bench of the cell array
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, carry_out;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   llc_pkg::llc_in_t [3:0] cell_in;
   logic set_reset, primary_cell_clock, carry_in;
   logic [3:0] cell_storage_element, table_q, port_b_q, sum_q;
   int err_total = 0;
   int cmp_count = 0;
   // Row: config, contents, inputs, table out, sum
   typedef struct {
      logic [12:0] cfg;
      logic [15:0] tab;
      llc_pkg::llc_in_t in;
      logic q;
      logic s;
   } llc_row_t;
   llc_row_t rows [7] = '{
      '{13'h0100, 16'h8000, 5'h0F, 1'b1, 1'b0},
      '{13'h0100, 16'h0010, 5'h04, 1'b1, 1'b1},
      '{13'h0000, 16'h0010, 5'h04, 1'b0, 1'b0},
      '{13'h0003, 16'h0002, 5'h01, 1'b1, 1'b1},
      '{13'h0100, 16'h7FFF, 5'h0F, 1'b0, 1'b1},
      '{13'h1100, 16'h0000, 5'h03, 1'b0, 1'b1},
      '{13'h1100, 16'h0000, 5'h02, 1'b0, 1'b0}};

   llc_fabric fab (.pclk(pclk), .cell_in(cell_in), .set_reset(set_reset),
      .primary_cell_clock(primary_cell_clock), .carry_in(carry_in));

   llc_cell #(.NCELL(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cell_in(cell_in),
      .set_reset(set_reset), .primary_cell_clock(primary_cell_clock),
      .carry_in(carry_in), .cell_storage_element(cell_storage_element),
      .table_q(table_q), .port_b_q(port_b_q), .sum_q(sum_q), .carry_out(carry_out));

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
         err_total++;
      end
   endtask

   // One bus transfer; an idle edge follows so calls never collide
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk({31'h0, pready}, 32'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // Cuts a hang short well beyond the few hundred cycles needed
   initial begin
      #500000;
      $display("[FAIL] %0t watchdog expired", $time);
      err_total++;
      complete_run;
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(8'h00, 32'h0);
      rdc(8'h10, 32'h0);
      rdc(8'h20, 32'h0);
      $display("test reset done");
      foreach (rows[i]) begin
         apb(1'b1, 8'h10, {19'h0, rows[i].cfg});
         apb(1'b1, 8'h20, {16'h0, rows[i].tab});
         fab.step(rows[i].in, 1'b0, 1'b0);
         repeat (3) @(posedge pclk);
         chk({31'h0, table_q[0]}, {31'h0, rows[i].q});
         chk({31'h0, sum_q[0]}, {31'h0, rows[i].s});
      end
      $display("test table rows done");
      // Cells 1 to 3 hold a one at address 0 so each passes the carry on
      for (int k = 1; k < 4; k++) begin
         apb(1'b1, 8'h20 + 8'(4 * k), 32'h1);
      end
      fab.set_carry(1'b1);
      fab.step(5'h03, 1'b0, 1'b0);
      @(posedge pclk);
      chk({31'h0, carry_out}, 32'h1);
      chk({28'h0, sum_q}, 32'h0);
      rdc(8'h00, 32'h1E0);
      fab.set_carry(1'b0);
      repeat (2) @(posedge pclk);
      chk({31'h0, carry_out}, 32'h0);
      chk({28'h0, sum_q}, 32'hF);
      $display("test carry done");
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, 8'h14, 32'hFFFF_E000);
      rdc(8'h14, 32'h0);
      $display("test bus edges done");
      apb(1'b1, 8'h10, 32'h101);
      apb(1'b1, 8'h20, 32'h0);
      fab.step(5'h15, 1'b1, 1'b1);
      fab.step(5'h15, 1'b1, 1'b0);
      fab.step(5'h16, 1'b0, 1'b1);
      fab.step(5'h05, 1'b0, 1'b0);
      rdc(8'h20, 32'h20);
      @(posedge pclk);
      chk({31'h0, table_q[0]}, 32'h1);
      chk({31'h0, port_b_q[0]}, 32'h1);
      // Registered read, second port addressed by cell 1 inputs (zero)
      apb(1'b1, 8'h10, 32'h10D);
      fab.step(5'h05, 1'b0, 1'b0);
      fab.step(5'h05, 1'b0, 1'b0);
      chk({31'h0, table_q[0]}, 32'h0);
      fab.step(5'h05, 1'b0, 1'b1);
      fab.step(5'h05, 1'b0, 1'b0);
      @(posedge pclk);
      chk({31'h0, table_q[0]}, 32'h1);
      chk({31'h0, port_b_q[0]}, 32'h0);
      $display("test memory done");
      apb(1'b1, 8'h10, 32'h022);
      apb(1'b1, 8'h20, 32'h0);
      // Cell 1 is a one-bit shifter fed from the tap of cell 0
      apb(1'b1, 8'h14, 32'h082);
      apb(1'b1, 8'h24, 32'h0);
      fab.step(5'h10, 1'b0, 1'b1);
      fab.step(5'h00, 1'b0, 1'b1);
      fab.step(5'h00, 1'b0, 1'b1);
      fab.step(5'h00, 1'b0, 1'b0);
      @(posedge pclk);
      chk({31'h0, table_q[0]}, 32'h1);
      chk({31'h0, table_q[1]}, 32'h0);
      rdc(8'h20, 32'h4);
      fab.step(5'h00, 1'b0, 1'b1);
      fab.step(5'h00, 1'b0, 1'b0);
      @(posedge pclk);
      chk({31'h0, table_q[1]}, 32'h1);
      chk({31'h0, table_q[0]}, 32'h0);
      rdc(8'h24, 32'h1);
      // Cell 1 back to a plain table that outputs one
      apb(1'b1, 8'h14, 32'h0);
      apb(1'b1, 8'h24, 32'h1);
      $display("test shift done");
      apb(1'b1, 8'h10, 32'h600);
      fab.step(5'h10, 1'b0, 1'b1);
      fab.step(5'h10, 1'b0, 1'b0);
      chk({31'h0, cell_storage_element[0]}, 32'h1);
      // Clear acts on the cell clock pulse and beats the load of e
      fab.step(5'h10, 1'b1, 1'b1);
      fab.step(5'h00, 1'b0, 1'b0);
      chk({31'h0, cell_storage_element[0]}, 32'h0);
      // Fifth input selects the next cell's table output
      apb(1'b1, 8'h10, 32'h800);
      fab.step(5'h10, 1'b0, 1'b1);
      fab.step(5'h00, 1'b0, 1'b0);
      chk({31'h0, cell_storage_element[0]}, 32'h1);
      fab.step(5'h00, 1'b0, 1'b1);
      fab.step(5'h00, 1'b0, 1'b0);
      chk({31'h0, cell_storage_element[0]}, 32'h0);
      // With a table in memory use, set/reset no longer clears
      apb(1'b1, 8'h18, 32'h1);
      fab.step(5'h10, 1'b1, 1'b1);
      fab.step(5'h00, 1'b0, 1'b0);
      chk({31'h0, cell_storage_element[0]}, 32'h1);
      $display("test storage done");
      complete_run;
   end
endmodule
